//--- rtl/pcb_pkg.sv
// Purpose: shared constants and types of the configuration register bank
// Assumes: 32-bit register words, byte addresses on an 8-bit offset space
// Notes: slot numbers index the writable storage words
package pcb_pkg;
   localparam int PCB_DATA_W = 32;
   localparam int PCB_ADDR_W = 8;
   localparam int PCB_STRB_W = 4;
   localparam int PCB_SLOTS = 8;
   localparam int PCB_SLOT_W = 3;

   localparam logic [7:0] PCB_OFF_IDS = 8'h00;
   localparam logic [7:0] PCB_OFF_CMD = 8'h04;
   localparam logic [7:0] PCB_OFF_CLASS = 8'h08;
   localparam logic [7:0] PCB_OFF_LAT = 8'h0c;
   localparam logic [7:0] PCB_OFF_IO = 8'h10;
   localparam logic [7:0] PCB_OFF_MEM = 8'h14;
   localparam logic [7:0] PCB_OFF_CARD = 8'h28;
   localparam logic [7:0] PCB_OFF_SUB = 8'h2c;
   localparam logic [7:0] PCB_OFF_ROM = 8'h30;
   localparam logic [7:0] PCB_OFF_CAP = 8'h34;
   localparam logic [7:0] PCB_OFF_INT = 8'h3c;
   localparam logic [7:0] PCB_OFF_DRV = 8'h40;
   localparam logic [7:0] PCB_OFF_MARK = 8'h80;
   localparam logic [7:0] PCB_OFF_PMC = 8'hc0;
   localparam logic [7:0] PCB_OFF_PMCS = 8'hc4;

   localparam logic [2:0] PCB_SL_CMD = 3'h0;
   localparam logic [2:0] PCB_SL_LAT = 3'h1;
   localparam logic [2:0] PCB_SL_IO = 3'h2;
   localparam logic [2:0] PCB_SL_MEM = 3'h3;
   localparam logic [2:0] PCB_SL_ROM = 3'h4;
   localparam logic [2:0] PCB_SL_INT = 3'h5;
   localparam logic [2:0] PCB_SL_DRV = 3'h6;
   localparam logic [2:0] PCB_SL_PMCS = 3'h7;

   localparam int PCB_IO_WIN_BITS = 8;
   localparam int PCB_MEM_WIN_BITS = 10;
   localparam int PCB_ROM_WIN_BITS = 18;
   localparam logic [31:0] PCB_IO_MASK = ~((32'h1 << PCB_IO_WIN_BITS) - 32'h1);
   localparam logic [31:0] PCB_MEM_MASK = ~((32'h1 << PCB_MEM_WIN_BITS) - 32'h1);
   localparam logic [31:0] PCB_ROM_MASK = ~((32'h1 << PCB_ROM_WIN_BITS) - 32'h1);

   localparam int PCB_CMD_IO = 0;
   localparam int PCB_CMD_MEM = 1;
   localparam int PCB_CMD_MASTER = 2;
   localparam int PCB_ROM_EN = 0;
   localparam int PCB_ST_PARITY = 31;
   localparam int PCB_ST_SYSERR = 30;
   localparam int PCB_ST_MABORT = 29;
   localparam int PCB_ST_TABORT = 28;
   localparam int PCB_ST_DPR = 24;
   localparam int PCB_PM_STATE_LSB = 0;
   localparam int PCB_PM_STATUS = 15;

   localparam logic [31:0] PCB_RW_MASK [PCB_SLOTS] = '{32'h00000147, 32'h0000ffff, PCB_IO_MASK,
      PCB_MEM_MASK, PCB_ROM_MASK | 32'h00000001, 32'h000000ff, 32'h0000ff00, 32'h00000103};
   localparam logic [31:0] PCB_W1C_MASK [PCB_SLOTS] = '{32'hf1000000, 32'h0, 32'h0, 32'h0,
      32'h0, 32'h0, 32'h0, 32'h00008000};
   localparam logic [31:0] PCB_RO_BITS [PCB_SLOTS] = '{32'h02900000, 32'h0, 32'h00000001, 32'h0,
      32'h0, 32'h00000100, 32'h0, 32'h0};
   localparam logic [31:0] PCB_RESET_VAL [PCB_SLOTS] = '{default: 32'h0};

   localparam logic [31:0] PCB_CLASS_VAL = 32'h02000000;
   localparam logic [31:0] PCB_CAP_PTR_VAL = 32'h000000c0;
   localparam logic [31:0] PCB_PM_CAP_VAL = 32'h00020001;
   localparam logic [1:0] PCB_RESP_OKAY = 2'b00;

   typedef enum logic [1:0] {PCB_WR_COLLECT = 2'b01, PCB_WR_RESP = 2'b10} pcb_wr_state_e;
   typedef enum logic [1:0] {PCB_RD_IDLE = 2'b01, PCB_RD_DATA = 2'b10} pcb_rd_state_e;
endpackage : pcb_pkg

//--- rtl/pcb_cfg_if.sv
// Purpose: carrier between the bus front end and the register storage
// Assumes: one write port, hardware set bits per word
// Notes: q holds stored bits only, fixed bits are added by the reader
interface pcb_cfg_if;
   import pcb_pkg::*;
   logic wr_en;
   logic [PCB_SLOT_W-1:0] wr_slot;
   logic [PCB_DATA_W-1:0] wr_data;
   logic [PCB_STRB_W-1:0] wr_strb;
   logic [PCB_DATA_W-1:0] set_bits [PCB_SLOTS];
   logic [PCB_DATA_W-1:0] q [PCB_SLOTS];
   modport bank (output wr_en, output wr_slot, output wr_data, output wr_strb, output set_bits, input q);
   modport store (input wr_en, input wr_slot, input wr_data, input wr_strb, input set_bits, output q);
endinterface : pcb_cfg_if

//--- rtl/pcb_cfg_store.sv
// Purpose: writable configuration words with byte lanes, masks and sticky bits
// Assumes: synchronous write strobe from the bus front end
// Notes: a hardware set in the same cycle as a clear leaves the bit set
module pcb_cfg_store (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   pcb_cfg_if.store cfg
);
   import pcb_pkg::*;

   for (genvar i = 0; i < PCB_SLOTS; i++) begin : g_word
      always_ff @(posedge sys_clk_in or posedge reset_in) begin
         if (reset_in) begin
            cfg.q[i] <= PCB_RESET_VAL[i];
         end else begin
            for (int b = 0; b < PCB_STRB_W; b++) begin
               if (cfg.wr_en && cfg.wr_slot == PCB_SLOT_W'(i) && cfg.wr_strb[b]) begin
                  cfg.q[i][b*8 +: 8] <= (((cfg.q[i][b*8 +: 8] & ~PCB_RW_MASK[i][b*8 +: 8])
                     | (cfg.wr_data[b*8 +: 8] & PCB_RW_MASK[i][b*8 +: 8]))
                     & ~(cfg.wr_data[b*8 +: 8] & PCB_W1C_MASK[i][b*8 +: 8]))
                     | cfg.set_bits[i][b*8 +: 8];
               end else begin
                  cfg.q[i][b*8 +: 8] <= cfg.q[i][b*8 +: 8] | cfg.set_bits[i][b*8 +: 8];
               end
            end
         end
      end
   end
endmodule : pcb_cfg_store

//--- rtl/pcb_cfg_bank.sv
// Purpose: configuration register bank of a bus-attached network controller
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes: identifiers and card data are captured once after reset release
//
// Register access over AXI4-Lite was decided locally.

// Notes on behaviour
// - hardware reset loads every default value
// - software reset leaves configuration untouched
// - byte, word, dword access by lanes
// - offset 00h returns loaded device, vendor ids
// - offset 04h holds command and status
// - offset 08h returns class code, revision
// - offset 28h returns card information pointer
// - offset 2ch returns subsystem ids
// - offset 30h rom base, 256KB window
// - offset 40h driver scratch space
// - offset c0h first power register
// - offset c4h power control and status
// - io or memory window reaches control registers
module pcb_cfg_bank #(
   parameter logic [7:0] REVISION = 8'h11,
   parameter logic [31:0] CHIP_MARK = 32'h5a5a0001
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [pcb_pkg::PCB_ADDR_W-1:0] awaddr_in,
   input wire logic wvalid_in,
   output logic wready_out,
   input wire logic [pcb_pkg::PCB_DATA_W-1:0] wdata_in,
   input wire logic [pcb_pkg::PCB_STRB_W-1:0] wstrb_in,
   output logic bvalid_out,
   input wire logic bready_in,
   output logic [1:0] bresp_out,
   input wire logic arvalid_in,
   output logic arready_out,
   input wire logic [pcb_pkg::PCB_ADDR_W-1:0] araddr_in,
   output logic rvalid_out,
   input wire logic rready_in,
   output logic [pcb_pkg::PCB_DATA_W-1:0] rdata_out,
   output logic [1:0] rresp_out,
   input wire logic [15:0] loaded_device_id_in,
   input wire logic [15:0] loaded_vendor_id_in,
   input wire logic [15:0] loaded_subsys_id_in,
   input wire logic [15:0] loaded_subsys_vendor_in,
   input wire logic [31:0] loaded_card_info_in,
   input wire logic parity_err_evt_in,
   input wire logic sys_err_evt_in,
   input wire logic master_abort_evt_in,
   input wire logic target_abort_evt_in,
   input wire logic data_parity_evt_in,
   input wire logic pme_evt_in,
   input wire logic [31:0] csr_addr_in,
   input wire logic csr_io_cycle_in,
   output logic io_space_en_out,
   output logic mem_space_en_out,
   output logic bus_master_en_out,
   output logic [1:0] power_state_out,
   output logic io_window_hit_out,
   output logic mem_window_hit_out,
   output logic rom_window_hit_out
);
   import pcb_pkg::*;

   pcb_cfg_if cfg ();

   pcb_cfg_store u_store (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .cfg(cfg.store)
   );

   // captured identity words
   logic loaded_r;
   logic [31:0] ids_r;
   logic [31:0] sub_ids_r;
   logic [31:0] card_info_r;

   // write channel state
   pcb_wr_state_e wr_st_r;
   logic awready_r;
   logic wready_r;
   logic aw_have_r;
   logic w_have_r;
   logic wr_pend_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic [PCB_ADDR_W-1:0] awaddr_r;
   logic [PCB_DATA_W-1:0] wdata_r;
   logic [PCB_STRB_W-1:0] wstrb_r;

   // read channel state
   pcb_rd_state_e rd_st_r;
   logic arready_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [PCB_DATA_W-1:0] rdata_r;

   // decoded outputs
   logic io_en_r;
   logic mem_en_r;
   logic master_en_r;
   logic [1:0] pm_state_r;
   logic io_hit_r;
   logic mem_hit_r;
   logic rom_hit_r;

   logic aw_fire;
   logic w_fire;
   logic aw_got;
   logic w_got;
   logic wr_hit;
   logic [PCB_SLOT_W-1:0] wr_slot;
   logic [PCB_DATA_W-1:0] rd_word;

   // maps an offset to a storage slot, bit 3 flags a writable word
   function automatic logic [PCB_SLOT_W:0] slot_of(input logic [PCB_ADDR_W-1:0] a);
      logic [PCB_ADDR_W-1:0] w;
      w = {a[PCB_ADDR_W-1:2], 2'b00};
      case (w)
         PCB_OFF_CMD: slot_of = {1'b1, PCB_SL_CMD};
         PCB_OFF_LAT: slot_of = {1'b1, PCB_SL_LAT};
         PCB_OFF_IO: slot_of = {1'b1, PCB_SL_IO};
         PCB_OFF_MEM: slot_of = {1'b1, PCB_SL_MEM};
         PCB_OFF_ROM: slot_of = {1'b1, PCB_SL_ROM};
         PCB_OFF_INT: slot_of = {1'b1, PCB_SL_INT};
         PCB_OFF_DRV: slot_of = {1'b1, PCB_SL_DRV};
         PCB_OFF_PMCS: slot_of = {1'b1, PCB_SL_PMCS};
         default: slot_of = '0;
      endcase
   endfunction : slot_of

   // caught one edge after release, so reads before that see zero
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         loaded_r <= 1'b0;
         ids_r <= '0;
         sub_ids_r <= '0;
         card_info_r <= '0;
      end else if (!loaded_r) begin
         loaded_r <= 1'b1;
         ids_r <= {loaded_device_id_in, loaded_vendor_id_in};
         sub_ids_r <= {loaded_subsys_id_in, loaded_subsys_vendor_in};
         card_info_r <= loaded_card_info_in;
      end
   end

   // status and power event bits; sticky in storage, set beats clear there
   always_comb begin
      for (int i = 0; i < PCB_SLOTS; i++) begin
         cfg.set_bits[i] = '0;
      end
      cfg.set_bits[PCB_SL_CMD][PCB_ST_PARITY] = parity_err_evt_in;
      cfg.set_bits[PCB_SL_CMD][PCB_ST_SYSERR] = sys_err_evt_in;
      cfg.set_bits[PCB_SL_CMD][PCB_ST_MABORT] = master_abort_evt_in;
      cfg.set_bits[PCB_SL_CMD][PCB_ST_TABORT] = target_abort_evt_in;
      cfg.set_bits[PCB_SL_CMD][PCB_ST_DPR] = data_parity_evt_in;
      cfg.set_bits[PCB_SL_PMCS][PCB_PM_STATUS] = pme_evt_in;
   end

   assign aw_fire = awvalid_in && awready_r;
   assign w_fire = wvalid_in && wready_r;
   assign aw_got = aw_have_r || aw_fire;
   assign w_got = w_have_r || w_fire;
   assign {wr_hit, wr_slot} = slot_of(awaddr_r);

   // write commits one edge after both halves are held
   assign cfg.wr_en = wr_pend_r && wr_hit;
   assign cfg.wr_slot = wr_slot;
   assign cfg.wr_data = wdata_r;
   assign cfg.wr_strb = wstrb_r;

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         wr_st_r <= PCB_WR_COLLECT;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         wr_pend_r <= 1'b0;
         bvalid_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else begin
         case (wr_st_r)
            PCB_WR_COLLECT: begin
               if (aw_fire) begin
                  awaddr_r <= awaddr_in;
               end
               if (w_fire) begin
                  wdata_r <= wdata_in;
                  wstrb_r <= wstrb_in;
               end
               aw_have_r <= aw_got;
               w_have_r <= w_got;
               awready_r <= !aw_got;
               wready_r <= !w_got;
               if (aw_got && w_got) begin
                  wr_pend_r <= 1'b1;
                  wr_st_r <= PCB_WR_RESP;
               end
            end
            PCB_WR_RESP: begin
               if (wr_pend_r) begin
                  wr_pend_r <= 1'b0;
                  bvalid_r <= 1'b1;
               end else if (bvalid_r && bready_in) begin
                  bvalid_r <= 1'b0;
                  aw_have_r <= 1'b0;
                  w_have_r <= 1'b0;
                  awready_r <= 1'b1;
                  wready_r <= 1'b1;
                  wr_st_r <= PCB_WR_COLLECT;
               end
            end
            default: begin
               wr_st_r <= PCB_WR_COLLECT;
            end
         endcase
      end
   end

   // unmapped offsets still answer okay, so probing software never faults
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         bresp_r <= PCB_RESP_OKAY;
         rresp_r <= PCB_RESP_OKAY;
      end else begin
         bresp_r <= PCB_RESP_OKAY;
         rresp_r <= PCB_RESP_OKAY;
      end
   end

   // read word assembly; whole word returned, the master keeps its lanes
   always_comb begin
      case ({araddr_in[PCB_ADDR_W-1:2], 2'b00})
         PCB_OFF_IDS: rd_word = ids_r;
         PCB_OFF_CMD: rd_word = cfg.q[PCB_SL_CMD] | PCB_RO_BITS[PCB_SL_CMD];
         PCB_OFF_CLASS: rd_word = PCB_CLASS_VAL | {24'h0, REVISION};
         PCB_OFF_LAT: rd_word = cfg.q[PCB_SL_LAT];
         PCB_OFF_IO: rd_word = cfg.q[PCB_SL_IO] | PCB_RO_BITS[PCB_SL_IO];
         PCB_OFF_MEM: rd_word = cfg.q[PCB_SL_MEM];
         PCB_OFF_CARD: rd_word = card_info_r;
         PCB_OFF_SUB: rd_word = sub_ids_r;
         PCB_OFF_ROM: rd_word = cfg.q[PCB_SL_ROM];
         PCB_OFF_CAP: rd_word = PCB_CAP_PTR_VAL;
         PCB_OFF_INT: rd_word = cfg.q[PCB_SL_INT] | PCB_RO_BITS[PCB_SL_INT];
         PCB_OFF_DRV: rd_word = cfg.q[PCB_SL_DRV];
         PCB_OFF_MARK: rd_word = CHIP_MARK;
         PCB_OFF_PMC: rd_word = PCB_PM_CAP_VAL;
         PCB_OFF_PMCS: rd_word = cfg.q[PCB_SL_PMCS];
         default: rd_word = '0;
      endcase
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         rd_st_r <= PCB_RD_IDLE;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
      end else begin
         case (rd_st_r)
            PCB_RD_IDLE: begin
               if (arvalid_in && arready_r) begin
                  arready_r <= 1'b0;
                  rvalid_r <= 1'b1;
                  rdata_r <= rd_word;
                  rd_st_r <= PCB_RD_DATA;
               end else begin
                  arready_r <= 1'b1;
               end
            end
            PCB_RD_DATA: begin
               if (rready_in) begin
                  rvalid_r <= 1'b0;
                  arready_r <= 1'b1;
                  rd_st_r <= PCB_RD_IDLE;
               end
            end
            default: begin
               rd_st_r <= PCB_RD_IDLE;
            end
         endcase
      end
   end

   // only the hardware reset clears this state; a software reset never reaches here
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         io_en_r <= 1'b0;
         mem_en_r <= 1'b0;
         master_en_r <= 1'b0;
         pm_state_r <= '0;
      end else begin
         io_en_r <= cfg.q[PCB_SL_CMD][PCB_CMD_IO];
         mem_en_r <= cfg.q[PCB_SL_CMD][PCB_CMD_MEM];
         master_en_r <= cfg.q[PCB_SL_CMD][PCB_CMD_MASTER];
         pm_state_r <= cfg.q[PCB_SL_PMCS][PCB_PM_STATE_LSB +: 2];
      end
   end

   // window decode registered once, so hits trail csr_addr_in by one cycle
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         io_hit_r <= 1'b0;
         mem_hit_r <= 1'b0;
         rom_hit_r <= 1'b0;
      end else begin
         io_hit_r <= io_en_r && csr_io_cycle_in
            && ((csr_addr_in & PCB_IO_MASK) == (cfg.q[PCB_SL_IO] & PCB_IO_MASK));
         mem_hit_r <= mem_en_r && !csr_io_cycle_in
            && ((csr_addr_in & PCB_MEM_MASK) == (cfg.q[PCB_SL_MEM] & PCB_MEM_MASK));
         rom_hit_r <= mem_en_r && !csr_io_cycle_in && cfg.q[PCB_SL_ROM][PCB_ROM_EN]
            && ((csr_addr_in & PCB_ROM_MASK) == (cfg.q[PCB_SL_ROM] & PCB_ROM_MASK));
      end
   end

   assign awready_out = awready_r;
   assign wready_out = wready_r;
   assign bvalid_out = bvalid_r;
   assign bresp_out = bresp_r;
   assign arready_out = arready_r;
   assign rvalid_out = rvalid_r;
   assign rdata_out = rdata_r;
   assign rresp_out = rresp_r;
   assign io_space_en_out = io_en_r;
   assign mem_space_en_out = mem_en_r;
   assign bus_master_en_out = master_en_r;
   assign power_state_out = pm_state_r;
   assign io_window_hit_out = io_hit_r;
   assign mem_window_hit_out = mem_hit_r;
   assign rom_window_hit_out = rom_hit_r;
endmodule : pcb_cfg_bank

//--- tb/pcb_cfg_bank_sva.sv
// Purpose: port-level checks of the configuration register bank
// Assumes: one clock, asynchronous active high reset
// Notes: hit checks look one cycle back, at what the decode sampled
module pcb_cfg_bank_sva (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic awvalid_in,
   input wire logic awready_out,
   input wire logic wvalid_in,
   input wire logic wready_out,
   input wire logic bvalid_out,
   input wire logic bready_in,
   input wire logic [1:0] bresp_out,
   input wire logic arvalid_in,
   input wire logic arready_out,
   input wire logic rvalid_out,
   input wire logic rready_in,
   input wire logic [31:0] rdata_out,
   input wire logic [1:0] rresp_out,
   input wire logic csr_io_cycle_in,
   input wire logic io_space_en_out,
   input wire logic mem_space_en_out,
   input wire logic [1:0] power_state_out,
   input wire logic io_window_hit_out,
   input wire logic mem_window_hit_out,
   input wire logic rom_window_hit_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   a_reset_clean: assert property ($fell(reset_in) |-> !awready_out && !bvalid_out && !io_space_en_out
      && power_state_out == 2'b00) else $error("outputs not cleared by reset");
   a_write_answer: assert property (awvalid_in && awready_out && wvalid_in && wready_out |-> ##2 bvalid_out)
      else $error("write response late");
   a_read_answer: assert property (arvalid_in && arready_out |=> rvalid_out && !arready_out)
      else $error("read data late");
   a_rdata_hold: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
      else $error("read data dropped before taken");
   a_bvalid_hold: assert property (bvalid_out && !bready_in |=> bvalid_out)
      else $error("write response dropped");
   a_resp_okay: assert property (bvalid_out || rvalid_out |-> bresp_out == 2'b00 && rresp_out == 2'b00)
      else $error("response not okay");
   a_io_hit_cause: assert property (io_window_hit_out |-> $past(io_space_en_out) && $past(csr_io_cycle_in))
      else $error("io hit without cause");
   a_mem_hit_cause: assert property (mem_window_hit_out |-> $past(mem_space_en_out) && !$past(csr_io_cycle_in))
      else $error("memory hit without cause");
   a_rom_hit_cause: assert property (rom_window_hit_out |-> $past(mem_space_en_out) && !$past(csr_io_cycle_in))
      else $error("rom hit without cause");
   c_write: cover property (bvalid_out && bready_in);
   c_read_slow: cover property (rvalid_out && !rready_in);
   c_rom_hit: cover property (rom_window_hit_out);
endmodule : pcb_cfg_bank_sva

//--- tb/pcb_host_model.sv
// Purpose: host bus controller issuing configuration accesses
// Assumes: aw and w offered together, one access at a time
// Notes: slow delays bready and rready by one cycle after the answer
module pcb_host_model (
   input wire logic sys_clk_in,
   output logic awvalid_out,
   output logic [7:0] awaddr_out,
   input wire logic awready_in,
   output logic wvalid_out,
   output logic [31:0] wdata_out,
   output logic [3:0] wstrb_out,
   input wire logic wready_in,
   input wire logic bvalid_in,
   output logic bready_out,
   output logic arvalid_out,
   output logic [7:0] araddr_out,
   input wire logic arready_in,
   input wire logic rvalid_in,
   output logic rready_out,
   input wire logic [31:0] rdata_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic slow = 1'b0;
   initial begin
      {awvalid_out, awaddr_out, wvalid_out, wdata_out, wstrb_out, bready_out, arvalid_out, araddr_out, rready_out} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr_out <= a;
      wdata_out <= d;
      wstrb_out <= s;
      awvalid_out <= 1'b1;
      wvalid_out <= 1'b1;
      bready_out <= !slow;
      while (!(aw_ok && w_ok)) begin
         @(posedge sys_clk_in);
         if (awready_in && !aw_ok) begin
            aw_ok = 1'b1;
            awvalid_out <= 1'b0;
         end
         if (wready_in && !w_ok) begin
            w_ok = 1'b1;
            wvalid_out <= 1'b0;
         end
      end
      do @(posedge sys_clk_in); while (!bvalid_in);
      if (slow) begin
         bready_out <= 1'b1;
         @(posedge sys_clk_in);
      end
      bready_out <= 1'b0;
      @(posedge sys_clk_in);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      araddr_out <= a;
      arvalid_out <= 1'b1;
      rready_out <= !slow;
      do @(posedge sys_clk_in); while (!arready_in);
      arvalid_out <= 1'b0;
      do @(posedge sys_clk_in); while (!rvalid_in);
      if (slow) begin
         rready_out <= 1'b1;
         @(posedge sys_clk_in);
      end
      d = rdata_in;
      rready_out <= 1'b0;
      @(posedge sys_clk_in);
   endtask : rd
endmodule : pcb_host_model

//--- tb/pcb_cfg_bank_tb_top.sv
// Purpose: self-checking bench of the configuration register bank
// Assumes: default bank parameters, identity inputs held constant
// Notes: table rows write then read back one word each
module pcb_cfg_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pcb_pkg::*;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e;} pcb_row_s;
   localparam logic [31:0] IDS = 32'hbe017a02; // arbitrary device and vendor ids
   localparam logic [31:0] SUB = 32'h3c044d05; // arbitrary subsystem ids
   localparam logic [31:0] CARD = 32'h00005678;
   localparam pcb_row_s ROWS [25] = '{
      '{8'h00, 32'hffffffff, 4'hf, IDS},
      '{8'h04, 32'hffffffff, 4'h0, 32'h02900000},
      '{8'h04, 32'hffffffff, 4'hf, 32'h02900147},
      '{8'h08, 32'hffffffff, 4'hf, 32'h02000011},
      '{8'h0c, 32'hffffffff, 4'h0, 32'h0},
      '{8'h0c, 32'hffffffff, 4'hf, 32'h0000ffff},
      '{8'h0c, 32'h12345678, 4'h2, 32'h000056ff},
      '{8'h0c, 32'h000000ab, 4'h1, 32'h000056ab},
      '{8'h10, 32'hffffffff, 4'h0, 32'h00000001},
      '{8'h10, 32'hffffffff, 4'hf, 32'hffffff01},
      '{8'h14, 32'hffffffff, 4'hf, 32'hfffffc00},
      '{8'h18, 32'hffffffff, 4'hf, 32'h0},
      '{8'h28, 32'hffffffff, 4'hf, CARD},
      '{8'h2c, 32'hffffffff, 4'hf, SUB},
      '{8'h30, 32'hffffffff, 4'h0, 32'h0},
      '{8'h30, 32'hffffffff, 4'hf, 32'hfffc0001},
      '{8'h34, 32'hffffffff, 4'hf, 32'h000000c0},
      '{8'h3c, 32'hffffffff, 4'hf, 32'h000001ff},
      '{8'h40, 32'hffffffff, 4'h0, 32'h0},
      '{8'h40, 32'hffffffff, 4'h3, 32'h0000ff00},
      '{8'h80, 32'h0, 4'hf, 32'h5a5a0001},
      '{8'hc0, 32'hffffffff, 4'hf, 32'h00020001},
      '{8'hc4, 32'hffffffff, 4'h0, 32'h0},
      '{8'hc4, 32'hffffffff, 4'hf, 32'h00000103},
      '{8'hfc, 32'hffffffff, 4'hf, 32'h0}};
   logic sys_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, pstate;
   logic [5:0] evt = 6'h0;
   logic [31:0] csr_a = 32'h0;
   logic csr_io = 1'b0;
   logic io_en, mem_en, bm_en, io_hit, mem_hit, rom_hit;
   logic [31:0] got;
   int n_mismatch = 0;
   int tests_run = 0;
   initial forever #50 sys_clk_in = ~sys_clk_in;
   pcb_host_model u_host (.sys_clk_in(sys_clk_in), .awvalid_out(awvalid), .awaddr_out(awaddr),
      .awready_in(awready), .wvalid_out(wvalid), .wdata_out(wdata), .wstrb_out(wstrb), .wready_in(wready),
      .bvalid_in(bvalid), .bready_out(bready), .arvalid_out(arvalid), .araddr_out(araddr),
      .arready_in(arready), .rvalid_in(rvalid), .rready_out(rready), .rdata_in(rdata));
   pcb_cfg_bank u_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .awvalid_in(awvalid), .awready_out(awready),
      .awaddr_in(awaddr), .wvalid_in(wvalid), .wready_out(wready), .wdata_in(wdata), .wstrb_in(wstrb),
      .bvalid_out(bvalid), .bready_in(bready), .bresp_out(bresp), .arvalid_in(arvalid), .arready_out(arready),
      .araddr_in(araddr), .rvalid_out(rvalid), .rready_in(rready), .rdata_out(rdata), .rresp_out(rresp),
      .loaded_device_id_in(IDS[31:16]), .loaded_vendor_id_in(IDS[15:0]), .loaded_subsys_id_in(SUB[31:16]),
      .loaded_subsys_vendor_in(SUB[15:0]), .loaded_card_info_in(CARD), .parity_err_evt_in(evt[0]),
      .sys_err_evt_in(evt[1]), .master_abort_evt_in(evt[2]), .target_abort_evt_in(evt[3]),
      .data_parity_evt_in(evt[4]), .pme_evt_in(evt[5]), .csr_addr_in(csr_a), .csr_io_cycle_in(csr_io),
      .io_space_en_out(io_en), .mem_space_en_out(mem_en), .bus_master_en_out(bm_en),
      .power_state_out(pstate), .io_window_hit_out(io_hit), .mem_window_hit_out(mem_hit),
      .rom_window_hit_out(rom_hit));
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         n_mismatch++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic wrd(input pcb_row_s r);
      u_host.wr(r.a, r.d, r.s);
      u_host.rd(r.a, got);
      check(got, r.e);
   endtask : wrd
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   // whole run is a few hundred cycles, so this leaves a wide margin
   initial begin
      repeat (20000) @(posedge sys_clk_in);
      n_mismatch++;
      close_out();
   end
   initial begin
      repeat (4) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      foreach (ROWS[i]) wrd(ROWS[i]);
      $display("table rows done");
      u_host.slow = 1'b1;
      evt <= 6'h3f;
      @(posedge sys_clk_in);
      evt <= 6'h0;
      wrd('{8'h0c, 32'h0, 4'h0, 32'h000056ab});
      u_host.rd(8'h04, got);
      check(got, 32'hf3900147);
      u_host.rd(8'hc4, got);
      check(got, 32'h00008103);
      wrd('{8'h04, 32'hf1000000, 4'h8, 32'h02900147});
      wrd('{8'hc4, 32'h00008103, 4'hf, 32'h00000103});
      check({29'h0, bm_en, mem_en, io_en}, 32'h7);
      check({30'h0, pstate}, 32'h3);
      $display("status and power test done");
      csr_a <= 32'hffffff10;
      csr_io <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      check({29'h0, io_hit, mem_hit, rom_hit}, 32'h4);
      csr_a <= 32'hfffffc04;
      csr_io <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      // the rom window at fffc0000 spans the memory window too, so both hit
      check({29'h0, io_hit, mem_hit, rom_hit}, 32'h3);
      csr_a <= 32'hfffc0000;
      repeat (2) @(posedge sys_clk_in);
      check({29'h0, io_hit, mem_hit, rom_hit}, 32'h1);
      $display("window test done");
      reset_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      check({29'h0, bm_en, mem_en, io_en}, 32'h0);
      wrd('{8'h0c, 32'h0, 4'h0, 32'h0});
      wrd('{8'h04, 32'h0, 4'h0, 32'h02900000});
      wrd('{8'h00, 32'h0, 4'h0, IDS});
      $display("second reset test done");
      close_out();
   end
endmodule : pcb_cfg_bank_tb_top
bind pcb_cfg_bank pcb_cfg_bank_sva u_sva (.sys_clk_in, .reset_in, .awvalid_in, .awready_out, .wvalid_in,
   .wready_out, .bvalid_out, .bready_in, .bresp_out, .arvalid_in, .arready_out, .rvalid_out, .rready_in,
   .rdata_out, .rresp_out, .csr_io_cycle_in, .io_space_en_out, .mem_space_en_out, .power_state_out,
   .io_window_hit_out, .mem_window_hit_out, .rom_window_hit_out);
